/* design/encoder_freeze_marker_capture.sv */
// Freeze and marker capture of reference and feedback encoder data.
//
// Notes on behaviour
// R01: Trigger input latches both encoders' counters.
// R02: Reference freeze stores revolutions and position.
// R03: Feedback freeze stores revolutions and position.
// R04: Edge select: zero rising, one falling.
// R05: Freeze results written only while enabled.
// R06: Freeze event sets both freeze flags.
// R07: Software clears freeze flags for new data.
// R08: Enabled: power-up/reinitialise_command sets trigger sources four; enable_q resets to 0, so only reinitialise_command sets them.
// R09: First channel source uses first freeze function.
// R10: Second channel source uses second freeze function.
// R11: Reference marker stores position and revolutions.
// R12: Reference marker sets its flag each time.
// R13: Feedback marker stores position and revolutions.
// R14: Feedback marker sets its flag each time.
// R15: Software reads marker data before next marker.
// R16: Inputs synchronised; one capture per pulse.
`timescale 1ns/1ns
`default_nettype none
module encoder_freeze_marker_capture
  import capture_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Avalon-MM slave
  input  wire logic [7:0]    address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [3:0]    byteenable,
  input  wire logic [31:0]   writedata,
  output logic      [31:0]   readdata,
  output logic               waitrequest,
  // Pins
  input  wire logic          capture_trigger_input,
  input  wire logic          ref_marker_in,
  input  wire logic          fb_marker_in,
  // Encoder counters
  input  wire enc_sample_t   ref_enc,
  input  wire enc_sample_t   fb_enc,
  // Freeze routing towards the host drive
  output logic      [7:0]    trig_src_first_fn,
  output logic      [7:0]    trig_src_second_fn,
  output freeze_route_t      ref_route,
  output freeze_route_t      fb_route,
  // Interrupt
  output logic               irq
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic        ack_q;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_mux;

  // Every access waits exactly one cycle so read data can be registered.
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_en       = write & ack_q;
  assign rd_en       = read & ~ack_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= (read | write) & ~ack_q;
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic trig_rise;
  logic trig_fall;
  logic ref_mk_rise;
  logic fb_mk_rise;

  pin_edge_sync u_trig_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (capture_trigger_input),
    .rise    (trig_rise),
    .fall    (trig_fall)
  );

  pin_edge_sync u_ref_mk_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (ref_marker_in),
    .rise    (ref_mk_rise),
    .fall    ()
  );

  pin_edge_sync u_fb_mk_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (fb_marker_in),
    .rise    (fb_mk_rise),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       enable_q;
  logic       edge_q;
  logic [3:0] src_sel_q;
  logic       reinitialise_command_q;
  logic       powerup_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      enable_q <= RST_ENABLE;
      edge_q   <= RST_EDGE;
      reinitialise_command_q <= 1'b0;
    end
    else
    begin
      reinitialise_command_q <= 1'b0;
      if (wr_en && address == OFF_CTRL && byteenable[0])
      begin
        enable_q <= writedata[CTRL_ENABLE_BIT];
        edge_q   <= writedata[CTRL_EDGE_BIT];
        reinitialise_command_q <= writedata[CTRL_REINITIALISE_COMMAND_BIT];
      end
    end
  end

  // The power-up pass runs once in the first cycle after reset release.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      powerup_q <= 1'b1;
    else
      powerup_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      src_sel_q <= RST_SRC_SEL;
    else if (wr_en && address == OFF_SRC_SEL && byteenable[0])
      src_sel_q <= writedata[3:0];
  end

  // ----------------------------------------------------------------
  // Host freeze trigger-source selections
  // ----------------------------------------------------------------
  logic [31:0] trig_word;
  assign trig_word = {16'h0000, trig_src_second_fn, trig_src_first_fn};

  logic [31:0] trig_new;
  assign trig_new = merge(trig_word, writedata, byteenable);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      trig_src_first_fn  <= RST_TRIG_SRC;
      trig_src_second_fn <= RST_TRIG_SRC;
    end
    else if ((powerup_q || reinitialise_command_q) && enable_q)
    begin
      trig_src_first_fn  <= TRIG_COMMON_LINE;  // R08
      trig_src_second_fn <= TRIG_COMMON_LINE;  // R08
    end
    else if (wr_en && address == OFF_TRIG_SRC)
    begin
      trig_src_first_fn  <= trig_new[TRIG_A_LSB +: 8];
      trig_src_second_fn <= trig_new[TRIG_B_LSB +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Freeze function routing
  // ----------------------------------------------------------------
  function automatic freeze_route_t route(input logic [1:0] src);
    freeze_route_t r;
    r.func = FN_NONE;
    r.chan = src;
    if (src == SRC_FIRST_CHAN)
      r.func = FN_FIRST;   // R09
    else if (src == SRC_SECOND_CHAN)
      r.func = FN_SECOND;  // R10
    return r;
  endfunction : route

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ref_route <= '{func: FN_NONE, chan: 2'h0};
      fb_route  <= '{func: FN_NONE, chan: 2'h0};
    end
    else
    begin
      ref_route <= route(src_sel_q[SRC_REF_LSB +: 2]);  // R09 R10
      fb_route  <= route(src_sel_q[SRC_FB_LSB +: 2]);   // R09 R10
    end
  end

  // ----------------------------------------------------------------
  // Capture events
  // ----------------------------------------------------------------
  logic       frz_edge;
  logic [3:0] flags_q;
  logic       ref_frz_take;
  logic       fb_frz_take;

  assign frz_edge     = edge_q ? trig_fall : trig_rise;  // R04 R01
  // A clear flag means the previous result was consumed.
  assign ref_frz_take = frz_edge & enable_q & ~flags_q[FLAG_REF_FRZ];  // R05 R07
  assign fb_frz_take  = frz_edge & enable_q & ~flags_q[FLAG_FB_FRZ];   // R05 R07

  enc_sample_t ref_frz_q;
  enc_sample_t fb_frz_q;
  enc_sample_t ref_mk_q;
  enc_sample_t fb_mk_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ref_frz_q <= '0;
    else if (ref_frz_take)
      ref_frz_q <= ref_enc;  // R02 R01
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fb_frz_q <= '0;
    else if (fb_frz_take)
      fb_frz_q <= fb_enc;  // R03 R01
  end

  // Marker data is overwritten on every marker; software must keep up.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ref_mk_q <= '0;
    else if (ref_mk_rise)
      ref_mk_q <= ref_enc;  // R11 R15
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fb_mk_q <= '0;
    else if (fb_mk_rise)
      fb_mk_q <= fb_enc;  // R13 R15
  end

  // ----------------------------------------------------------------
  // Capture flags: software writes zero to clear, an event wins.
  // ----------------------------------------------------------------
  logic [3:0] evt;
  logic [3:0] flag_clr;

  assign evt      = {fb_mk_rise, ref_mk_rise, ref_frz_take, fb_frz_take};
  assign flag_clr = (wr_en && address == OFF_FLAGS && byteenable[0]) ? ~writedata[3:0] : 4'h0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flags_q <= RST_FLAGS;
    else
      flags_q <= (flags_q & ~flag_clr) | evt;  // R06 R12 R14
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [3:0] stat_clr;

  assign stat_clr = (wr_en && address == OFF_IRQ_STATUS && byteenable[0]) ? writedata[3:0] : 4'h0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_stat_q <= RST_FLAGS;
    else
      irq_stat_q <= (irq_stat_q & ~stat_clr) | evt;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_mask_q <= RST_IRQ_MASK;
    else if (wr_en && address == OFF_IRQ_MASK && byteenable[0])
      irq_mask_q <= writedata[3:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = RST_WORD;
    if (address == OFF_CTRL)
      rd_mux = {29'h0000_0000, 1'b0, edge_q, enable_q};
    else if (address == OFF_SRC_SEL)
      rd_mux = {28'h000_0000, src_sel_q};
    else if (address == OFF_FLAGS)
      rd_mux = {28'h000_0000, flags_q};
    else if (address == OFF_TRIG_SRC)
      rd_mux = trig_word;
    else if (address == OFF_FB_FRZ_POS)
      rd_mux = fb_frz_q.pos;
    else if (address == OFF_FB_FRZ_REV)
      rd_mux = fb_frz_q.revs;
    else if (address == OFF_REF_FRZ_POS)
      rd_mux = ref_frz_q.pos;
    else if (address == OFF_REF_FRZ_REV)
      rd_mux = ref_frz_q.revs;
    else if (address == OFF_REF_MK_POS)
      rd_mux = ref_mk_q.pos;
    else if (address == OFF_REF_MK_REV)
      rd_mux = ref_mk_q.revs;
    else if (address == OFF_FB_MK_POS)
      rd_mux = fb_mk_q.pos;
    else if (address == OFF_FB_MK_REV)
      rd_mux = fb_mk_q.revs;
    else if (address == OFF_IRQ_STATUS)
      rd_mux = {28'h000_0000, irq_stat_q};
    else if (address == OFF_IRQ_MASK)
      rd_mux = {28'h000_0000, irq_mask_q};
  end

  // Read data is registered in the waiting cycle and held until the next read.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      readdata <= RST_WORD;
    else if (rd_en)
      readdata <= rd_mux;
  end

endmodule : encoder_freeze_marker_capture
`default_nettype wire

/* design/capture_pkg.sv */
// Package with register map, reset values and carrier types for the capture block.
package capture_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_SRC_SEL     = 8'h04;
  localparam logic [7:0] OFF_FLAGS       = 8'h08;
  localparam logic [7:0] OFF_TRIG_SRC    = 8'h0C;
  localparam logic [7:0] OFF_FB_FRZ_POS  = 8'h10;
  localparam logic [7:0] OFF_FB_FRZ_REV  = 8'h14;
  localparam logic [7:0] OFF_REF_FRZ_POS = 8'h18;
  localparam logic [7:0] OFF_REF_FRZ_REV = 8'h1C;
  localparam logic [7:0] OFF_REF_MK_POS  = 8'h20;
  localparam logic [7:0] OFF_REF_MK_REV  = 8'h24;
  localparam logic [7:0] OFF_FB_MK_POS   = 8'h28;
  localparam logic [7:0] OFF_FB_MK_REV   = 8'h2C;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h30;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_EDGE_BIT   = 1;
  localparam int CTRL_REINITIALISE_COMMAND_BIT = 2;
  localparam int FLAG_FB_FRZ     = 0;
  localparam int FLAG_REF_FRZ    = 1;
  localparam int FLAG_REF_MK     = 2;
  localparam int FLAG_FB_MK      = 3;
  localparam int SRC_REF_LSB     = 0;
  localparam int SRC_FB_LSB      = 2;
  localparam int TRIG_A_LSB      = 0;
  localparam int TRIG_B_LSB      = 8;

  // ----------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TRIG_COMMON_LINE  = 8'h04;
  localparam logic [1:0] SRC_FIRST_CHAN    = 2'h1;
  localparam logic [1:0] SRC_SECOND_CHAN   = 2'h2;
  localparam logic       RST_ENABLE        = 1'b0;
  localparam logic       RST_EDGE          = 1'b0;
  localparam logic [3:0] RST_SRC_SEL       = 4'h0;
  localparam logic [3:0] RST_FLAGS         = 4'h0;
  localparam logic [7:0] RST_TRIG_SRC      = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK      = 4'h0;
  localparam logic [31:0] RST_WORD         = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_NONE   = 2'b00,
    FN_FIRST  = 2'b01,
    FN_SECOND = 2'b10
  } freeze_fn_t;

  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] revs;
  } enc_sample_t;

  typedef struct packed {
    freeze_fn_t  func;
    logic [1:0]  chan;
  } freeze_route_t;

endpackage : capture_pkg

/* design/pin_edge_sync.sv */
// Three-stage pin synchroniser with agreement filter and single-cycle edge pulses.
`timescale 1ns/1ns
`default_nettype none
module pin_edge_sync
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin and edge pulses
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted only when the second and third stage agree.
  assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lvl_q <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl_d;
      rise  <= lvl_d & ~lvl_q;  // R16
      fall  <= ~lvl_d & lvl_q;  // R16
    end
  end

endmodule : pin_edge_sync
`default_nettype wire

/* tb/capture_assertions.sv */
// Port-level checker for the freeze and marker capture block.
`timescale 1ns/1ns
`default_nettype none
module capture_checker
  import capture_pkg::*;
(
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          rst,
  // Register bus
  input wire logic [7:0]    address,
  input wire logic          read,
  input wire logic          write,
  input wire logic [3:0]    byteenable,
  input wire logic [31:0]   writedata,
  input wire logic [31:0]   readdata,
  input wire logic          waitrequest,
  // Routing and interrupt
  input wire logic [7:0]    trig_src_first_fn,
  input wire logic [7:0]    trig_src_second_fn,
  input wire freeze_route_t ref_route,
  input wire freeze_route_t fb_route,
  input wire logic          irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic req;
  wire logic rd_ok;
  wire logic wr_ok;
  assign req   = read | write;
  assign rd_ok = read & ~waitrequest;
  assign wr_ok = write & ~waitrequest & byteenable[0];
  property p_answer;
    req && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after one wait state");
  property p_one_wait;
    req && !waitrequest |=> waitrequest || !req;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest low twice");
  property p_idle;
    !req |-> !waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  property p_rd_hold;
    $changed(readdata) |-> rd_ok;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved outside a read");
  property p_unmapped;
    rd_ok && address > OFF_IRQ_MASK |-> readdata == RST_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_rd;
    rd_ok && address == OFF_CTRL |-> !readdata[CTRL_REINITIALISE_COMMAND_BIT];
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("reinitialise_command bit reads one");
  property p_reinitialise_command;
    wr_ok && address == OFF_CTRL && writedata[CTRL_ENABLE_BIT] && writedata[CTRL_REINITIALISE_COMMAND_BIT]
      |-> ##[1:3] trig_src_first_fn == TRIG_COMMON_LINE && trig_src_second_fn == TRIG_COMMON_LINE;
  endproperty
  a_reinitialise_command: assert property (p_reinitialise_command) else $error("trigger sources not set");
  property p_route_first;
    wr_ok && address == OFF_SRC_SEL && writedata[1:0] == SRC_FIRST_CHAN
      |-> ##[1:3] ref_route == {FN_FIRST, SRC_FIRST_CHAN};
  endproperty
  a_route_first: assert property (p_route_first) else $error("first route wrong");
  property p_route_second;
    wr_ok && address == OFF_SRC_SEL && writedata[3:2] == SRC_SECOND_CHAN
      |-> ##[1:3] fb_route == {FN_SECOND, SRC_SECOND_CHAN};
  endproperty
  a_route_second: assert property (p_route_second) else $error("second route wrong");
  property p_mask_off;
    wr_ok && address == OFF_IRQ_MASK && writedata[3:0] == 4'h0 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq survives full mask");
  c_flags: cover property (wr_ok && address == OFF_FLAGS);
  c_irq: cover property ($rose(irq));
  c_marker: cover property (rd_ok && address == OFF_REF_MK_POS);
endmodule : capture_checker

bind encoder_freeze_marker_capture capture_checker chk_u (.clk_sys(clk_sys), .rst(rst),
  .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .trig_src_first_fn(trig_src_first_fn), .trig_src_second_fn(trig_src_second_fn),
  .ref_route(ref_route), .fb_route(fb_route), .irq(irq));
`default_nettype wire

/* tb/capture_partner.sv */
// Encoder counters and pin drivers standing for the drive side.
`timescale 1ns/1ns
`default_nettype none
module capture_partner
  import capture_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bench commands
  input  wire logic        load,
  input  wire logic        run,
  input  wire enc_sample_t ref_set,
  input  wire enc_sample_t fb_set,
  input  wire logic [2:0]  pins_set,
  // Towards the block
  output enc_sample_t      ref_enc,
  output enc_sample_t      fb_enc,
  output logic [2:0]       pins
);
  // Counters move only while run is high, so a held value is a known capture target.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ref_enc <= '0;
      fb_enc  <= '0;
      pins    <= 3'h0;
    end
    else
    begin
      pins <= pins_set;
      if (load)
      begin
        ref_enc <= ref_set;
        fb_enc  <= fb_set;
      end
      else if (run)
      begin
        ref_enc.pos <= ref_enc.pos + 32'h0000_0001;
        fb_enc.pos  <= fb_enc.pos - 32'h0000_0001;
      end
    end
  end
endmodule : capture_partner
`default_nettype wire

/* tb/test_encoder_freeze_marker_capture.sv */
// Self-checking bench for the freeze and marker capture block.
`timescale 1ns/1ns
`default_nettype none
module test_encoder_freeze_marker_capture
  import capture_pkg::*;
;
  logic          clk_sys;
  logic          rst;
  logic [7:0]    address;
  logic          read;
  logic          write;
  logic [3:0]    byteenable;
  logic [31:0]   writedata;
  logic [31:0]   readdata;
  logic          waitrequest;
  logic [7:0]    trig_a;
  logic [7:0]    trig_b;
  freeze_route_t ref_route;
  freeze_route_t fb_route;
  logic          irq;
  logic          load;
  logic          run;
  enc_sample_t   ref_set;
  enc_sample_t   fb_set;
  enc_sample_t   ref_enc;
  enc_sample_t   fb_enc;
  enc_sample_t   old_r;
  enc_sample_t   old_f;
  logic [2:0]    pins_set;
  logic [2:0]    pins;
  logic [31:0]   q;
  logic [31:0]   v;
  logic [31:0]   seed;
  int            err_count = 0;
  int            checks_done = 0;
  int            cyc = 0;

  encoder_freeze_marker_capture dut_u (.clk_sys(clk_sys), .rst(rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .capture_trigger_input(pins[0]),
    .ref_marker_in(pins[1]), .fb_marker_in(pins[2]), .ref_enc(ref_enc), .fb_enc(fb_enc),
    .trig_src_first_fn(trig_a), .trig_src_second_fn(trig_b), .ref_route(ref_route),
    .fb_route(fb_route), .irq(irq));
  capture_partner enc_u (.clk_sys(clk_sys), .rst(rst), .load(load), .run(run),
    .ref_set(ref_set), .fb_set(fb_set), .pins_set(pins_set), .ref_enc(ref_enc),
    .fb_enc(fb_enc), .pins(pins));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic freeze_route_t exp_route(input logic [1:0] s);
    freeze_fn_t f;
    f = (s == SRC_FIRST_CHAN) ? FN_FIRST : ((s == SRC_SECOND_CHAN) ? FN_SECOND : FN_NONE);
    return freeze_route_t'{f, s};
  endfunction : exp_route

  task end_sim;
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // A hung waitrequest is cut short by the cycle watchdog.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    do
      @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q, e);
  endtask : rchk

  task pin(input int i, input logic lv);
    @(posedge clk_sys);
    pins_set[i] <= lv;
    repeat (10) @(posedge clk_sys);
  endtask : pin

  task setenc;
    @(posedge clk_sys);
    ref_set <= {rnd(), rnd()};
    fb_set  <= {rnd(), rnd()};
    load    <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : setenc

  task frz_chk(input enc_sample_t r, input enc_sample_t f);
    rchk(OFF_FB_FRZ_POS, f.pos);
    rchk(OFF_FB_FRZ_REV, f.revs);
    rchk(OFF_REF_FRZ_POS, r.pos);
    rchk(OFF_REF_FRZ_REV, r.revs);
  endtask : frz_chk

  task mk_chk(input int i, input enc_sample_t e);
    rchk(8'(OFF_REF_MK_POS + 8 * (i - 1)), e.pos);
    rchk(8'(OFF_REF_MK_REV + 8 * (i - 1)), e.revs);
  endtask : mk_chk

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst        = 1'b1;
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    byteenable = 4'hF;
    writedata  = 32'h0000_0000;
    load       = 1'b0;
    run        = 1'b1;
    ref_set    = '0;
    fb_set     = '0;
    pins_set   = 3'h0;
    seed       = 32'h0000_382F;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8'h38; a += 4)
      rchk(8'(a), RST_WORD);
    wr(8'h3C, rnd());
    rchk(8'h3C, RST_WORD);
    run <= 1'b0;
    v = rnd();
    wr(OFF_TRIG_SRC, v);
    @(posedge clk_sys);
    chk("trig_a", {24'h0, trig_a}, {24'h0, v[7:0]});
    chk("trig_b", {24'h0, trig_b}, {24'h0, v[15:8]});
    wr(OFF_CTRL, 32'h0000_0005);
    repeat (3) @(posedge clk_sys);
    chk("trig_a", {24'h0, trig_a}, {24'h0, TRIG_COMMON_LINE});
    chk("trig_b", {24'h0, trig_b}, {24'h0, TRIG_COMMON_LINE});
    rchk(OFF_CTRL, 32'h0000_0001);
    for (int i = 1; i < 4; i++)
    begin
      wr(OFF_SRC_SEL, 32'((3 - i) * 4 + i));
      repeat (3) @(posedge clk_sys);
      chk("ref_route", 32'(ref_route), 32'(exp_route(2'(i))));
      chk("fb_route", 32'(fb_route), 32'(exp_route(2'(3 - i))));
    end
    setenc();
    pin(0, 1'b1);
    frz_chk(ref_set, fb_set);
    rchk(OFF_FLAGS, 32'h0000_0003);
    old_r = ref_set;
    old_f = fb_set;
    pin(0, 1'b0);
    setenc();
    pin(0, 1'b1);
    frz_chk(old_r, old_f);
    wr(OFF_FLAGS, 32'h0000_000C);
    rchk(OFF_FLAGS, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0003);
    pin(0, 1'b0);
    frz_chk(ref_set, fb_set);
    wr(OFF_FLAGS, 32'h0000_000C);
    old_r = ref_set;
    old_f = fb_set;
    setenc();
    pin(0, 1'b1);
    rchk(OFF_FLAGS, 32'h0000_0000);
    frz_chk(old_r, old_f);
    wr(OFF_CTRL, 32'h0000_0002);
    pin(0, 1'b0);
    frz_chk(old_r, old_f);
    rchk(OFF_FLAGS, 32'h0000_0000);
    for (int i = 1; i < 3; i++)
    begin
      setenc();
      pin(i, 1'b1);
      old_r = (i == 1) ? ref_set : fb_set;
      mk_chk(i, old_r);
      setenc();
      pin(i, 1'b0);
      mk_chk(i, old_r);
      rchk(OFF_FLAGS, 32'(2 << i));
      setenc();
      pin(i, 1'b1);
      mk_chk(i, (i == 1) ? ref_set : fb_set);
      pin(i, 1'b0);
      wr(OFF_FLAGS, 32'h0000_0000);
      rchk(OFF_FLAGS, 32'h0000_0000);
    end
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    wr(OFF_IRQ_MASK, 32'h0000_000C);
    wr(OFF_IRQ_STATUS, 32'h0000_000C);
    repeat (3) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rchk(OFF_IRQ_STATUS, 32'h0000_0003);
    end_sim();
  end
endmodule : test_encoder_freeze_marker_capture
`default_nettype wire
